// *** svi_pkg.sv ***
// svi_pkg: constants shared by the single-vector interrupt logic
package svi_pkg;
    // ********************************
    // register map
    // ********************************
    localparam logic [7:0]  SYSTEM_MODE_ADDR = 8'hDF;
    localparam int          GIE_BIT          = 3;
    localparam logic [3:0]  MODE_RESET       = 4'h0;
    localparam int          MODE_WIDTH       = 4;
    // ********************************
    // vector and sources
    // ********************************
    localparam logic [15:0] VECTOR_HI_ADDR   = 16'h0000;
    localparam logic [15:0] VECTOR_LO_ADDR   = 16'h0001;
    localparam int          NUM_SOURCES      = 4;
    localparam int          SRC_PWM_OVF      = 0;
    localparam int          SRC_T0_MATCH     = 1;
    localparam int          SRC_EXT_A        = 2;
    localparam int          SRC_EXT_B        = 3;
    localparam logic [NUM_SOURCES-1:0] PEND_RESET = 4'h0;

    typedef enum logic [1:0] {
        SVI_STK_PCL,
        SVI_STK_PCH,
        SVI_STK_FLAGS
    } svi_stk_e;
endpackage : svi_pkg

// *** svi_pin_sync.sv ***
// svi_pin_sync: three-stage synchroniser with agreement filter for a pin
`timescale 1ns/1ns
module svi_pin_sync
    import svi_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level,
    output logic      rise
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // change counts once stages two and three agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
        end else if (s2 == s3) begin
            level <= s3;
        end
    end

    assign rise = (s2 == s3) && s3 && !level;
endmodule : svi_pin_sync

// *** svi_pending.sv ***
// svi_pending: one sticky pending flag with write-zero-to-clear
`timescale 1ns/1ns
module svi_pending
    import svi_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic set_evt,
    input  wire logic wr_en,
    input  wire logic wr_bit,
    output logic      pending
);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= 1'b0;
        end else if (set_evt) begin
            pending <= 1'b1;                         // [R06]
        end else if (wr_en && !wr_bit) begin
            pending <= 1'b0;                         // [R15]
        end
    end

    held_until_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R06]
        pending && !(wr_en && !wr_bit) |=> pending)
        else $error("pending flag dropped without a clear");
    write_one_keeps_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R15]
        !pending && !set_evt |=> !pending)
        else $error("pending flag set without an event");
endmodule : svi_pending

// *** svi_core.sv ***
// svi_core: single-vector interrupt controller with stacking sequencer
//
// How it works
// R01: every source shares one vector fetched from program memory at 0000H.
// R02: the global enable is bit 3 of the system mode register at DFH.
// R03: software must run the enable instruction after reset, since the global enable resets to 0.
// R04: a request is serviced only when both the global and the source enable are set.
// R05: there is no priority logic; software polls pending flags to pick the order.
// R06: a source raises its pending flag to 1 and it stays until software clears it.
// R07: the handler must clear its pending flag before the return instruction.
// R08: a request is accepted only at an instruction boundary and then acknowledged to the core.
// R09: the first step of the interrupt cycle clears the global enable.
// R10: three bytes are pushed: PC low, PC high, then flags.
// R11: the handler address is read high byte from 0000H, low byte from 0001H, then branched to.
// R12: the return instruction pops flags and PC and sets the global enable.
// R13: there are exactly four sources: PWM overflow, timer 0 match, two external pins.
// R14: software may write the global enable directly, though the instructions are preferred.
// R15: a pending flag reads 1 while pending; writing 0 clears it, writing 1 has no effect.
// R16: the request is the OR of pending AND source enable, gated by the global enable.
`timescale 1ns/1ns
module svi_core
    import svi_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    // register file port toward the core
    input  wire logic [7:0]             reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic [7:0]             reg_wdata,
    output logic      [7:0]             reg_rdata,
    output logic                        reg_hit,
    // instruction control from the core
    input  wire logic                   instr_end,
    input  wire logic                   enable_interrupts_instr,
    input  wire logic                   mask_all_instr,
    input  wire logic                   return_from_isr,
    // sources
    input  wire logic                   pwm_ovf_evt,
    input  wire logic                   t0_match_evt,
    input  wire logic                   ext_irq_line_a,
    input  wire logic                   ext_irq_line_b,
    input  wire logic [NUM_SOURCES-1:0] src_enable,
    input  wire logic [NUM_SOURCES-1:0] pend_wr,
    input  wire logic [NUM_SOURCES-1:0] pend_wdata,
    output logic      [NUM_SOURCES-1:0] pending,
    // interrupt machine cycle toward the core
    input  wire logic [15:0]            pc_value,
    input  wire logic [7:0]             flags_value,
    input  wire logic                   mem_ready,
    input  wire logic [7:0]             mem_rdata,
    output logic                        irq_request,
    output logic                        irq_ack,
    output logic                        stack_push,
    output logic      [7:0]             stack_data,
    output logic                        vec_read,
    output logic      [15:0]            vec_addr,
    output logic                        branch,
    output logic      [15:0]            branch_target,
    output logic                        irq_busy
);
    // ********************************
    // state and system mode register
    // ********************************
    typedef enum logic [2:0] {
        SVI_IDLE,
        SVI_PUSH,
        SVI_VEC_HI,
        SVI_VEC_LO,
        SVI_JUMP
    } svi_state_e;

    svi_state_e             state;
    svi_stk_e               stk_step;
    logic [MODE_WIDTH-1:0]  system_mode_reg;
    logic [7:0]             vec_hi;
    logic [7:0]             vec_lo;
    logic [NUM_SOURCES-1:0] src_evt;
    logic                   global_irq_enable;
    logic                   mode_write;
    logic                   take_irq;

    function automatic logic addr_is_mode(input logic [7:0] a);
        addr_is_mode = (a == SYSTEM_MODE_ADDR);
    endfunction : addr_is_mode

    assign global_irq_enable = system_mode_reg[GIE_BIT];
    assign mode_write        = reg_wr && addr_is_mode(reg_addr);

    // ********************************
    // sources and pending flags
    // ********************************
    // external lines act on the rising edge of the filtered level
    svi_pin_sync u_sync_a (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin     (ext_irq_line_a),
        .level   (),
        .rise    (src_evt[SRC_EXT_A])
    );
    svi_pin_sync u_sync_b (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin     (ext_irq_line_b),
        .level   (),
        .rise    (src_evt[SRC_EXT_B])
    );
    assign src_evt[SRC_PWM_OVF]  = pwm_ovf_evt;                    // [R13]
    assign src_evt[SRC_T0_MATCH] = t0_match_evt;                   // [R13]

    // flags only set here; the handler clears them by write
    generate
        for (genvar i = 0; i < NUM_SOURCES; i++) begin : g_pend
            svi_pending u_pend (
                .ref_clk (ref_clk),
                .rst_n   (rst_n),
                .set_evt (src_evt[i]),
                .wr_en   (pend_wr[i]),
                .wr_bit  (pend_wdata[i]),
                .pending (pending[i])
            );
        end
    endgenerate

    // no priority: any enabled pending flag raises the single request
    assign irq_request = global_irq_enable && |(pending & src_enable); // [R16] [R04] [R05]
    assign take_irq    = (state == SVI_IDLE) && instr_end && irq_request; // [R08]
    assign irq_ack     = take_irq;                                 // [R08]
    assign irq_busy    = (state != SVI_IDLE);

    // ********************************
    // system mode register
    // ********************************
    // the machine cycle clear wins over a same-cycle software write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            system_mode_reg <= MODE_RESET;                         // [R03]
        end else begin
            if (mode_write) begin
                system_mode_reg <= reg_wdata[MODE_WIDTH-1:0];      // [R02] [R14]
            end
            if (enable_interrupts_instr) begin
                system_mode_reg[GIE_BIT] <= 1'b1;
            end
            if (mask_all_instr) begin
                system_mode_reg[GIE_BIT] <= 1'b0;
            end
            if (return_from_isr) begin
                system_mode_reg[GIE_BIT] <= 1'b1;                  // [R12]
            end
            if (take_irq) begin
                system_mode_reg[GIE_BIT] <= 1'b0;                  // [R09]
            end
        end
    end

    assign reg_hit   = addr_is_mode(reg_addr);
    // upper four bits are unused and read as zero
    assign reg_rdata = reg_hit ? {4'h0, system_mode_reg} : 8'h00;  // [R02]

    // ********************************
    // interrupt machine cycle
    // ********************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= SVI_IDLE;
            stk_step <= SVI_STK_PCL;
        end else begin
            unique case (state)
                SVI_IDLE: begin
                    if (take_irq) begin
                        state    <= SVI_PUSH;
                        stk_step <= SVI_STK_PCL;
                    end
                end
                SVI_PUSH: begin
                    if (mem_ready) begin
                        unique case (stk_step)
                            SVI_STK_PCL:   stk_step <= SVI_STK_PCH;   // [R10]
                            SVI_STK_PCH:   stk_step <= SVI_STK_FLAGS; // [R10]
                            SVI_STK_FLAGS: state    <= SVI_VEC_HI;
                            default:       stk_step <= SVI_STK_PCL;
                        endcase
                    end
                end
                SVI_VEC_HI: begin
                    if (mem_ready) begin
                        state <= SVI_VEC_LO;
                    end
                end
                SVI_VEC_LO: begin
                    if (mem_ready) begin
                        state <= SVI_JUMP;
                    end
                end
                SVI_JUMP: begin
                    state <= SVI_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            vec_hi <= 8'h00;
            vec_lo <= 8'h00;
        end else begin
            if (state == SVI_VEC_HI && mem_ready) begin
                vec_hi <= mem_rdata;                               // [R11]
            end
            if (state == SVI_VEC_LO && mem_ready) begin
                vec_lo <= mem_rdata;                               // [R11]
            end
        end
    end

    // data to the stack is registered: PC low, PC high, flags
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_data <= 8'h00;
        end else if (take_irq) begin
            stack_data <= pc_value[7:0];                           // [R10]
        end else if (state == SVI_PUSH && mem_ready) begin
            unique case (stk_step)
                SVI_STK_PCL:   stack_data <= pc_value[15:8];       // [R10]
                SVI_STK_PCH:   stack_data <= flags_value;          // [R10]
                default:       stack_data <= 8'h00;
            endcase
        end
    end

    assign stack_push    = (state == SVI_PUSH);
    assign vec_read      = (state == SVI_VEC_HI) || (state == SVI_VEC_LO);
    // one vector for all sources
    assign vec_addr      = (state == SVI_VEC_LO) ? VECTOR_LO_ADDR : VECTOR_HI_ADDR; // [R01]
    assign branch        = (state == SVI_JUMP);
    assign branch_target = {vec_hi, vec_lo};                       // [R11]

    // ********************************
    // checks
    // ********************************
    gie_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R09]
        take_irq |=> !global_irq_enable)
        else $error("global enable not cleared on acceptance");
    reti_sets_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
        return_from_isr && !take_irq |=> global_irq_enable)
        else $error("return did not set global enable");
    accept_boundary_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R08]
        irq_ack |-> instr_end && global_irq_enable)
        else $error("acknowledge outside an instruction boundary");
    busy_no_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R08]
        irq_busy |-> !irq_ack)
        else $error("acknowledge while a machine cycle runs");
    request_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R16]
        irq_request == (global_irq_enable && ((pending & src_enable) != '0)))
        else $error("request does not match enabled pending flags");
    source_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R04]
        irq_ack |-> (pending & src_enable) != '0)
        else $error("acknowledge without an enabled source");
    push_order_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
        irq_ack ##1 mem_ready[*3] |-> ##1 state == SVI_VEC_HI)
        else $error("stacking did not take three bytes");
    first_byte_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
        irq_ack |=> stack_push && {8'h00, stack_data} == ($past(pc_value) & 16'h00FF))
        else $error("first pushed byte is not PC low");
    push_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
        stack_push && !mem_ready |=> $stable(stack_data))
        else $error("stack byte changed while the stack was stalled");
    idle_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
        !irq_busy |-> !stack_push && !vec_read && !branch)
        else $error("stack or vector access outside a machine cycle");
    vector_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R01]
        vec_read |-> vec_addr == ((state == SVI_VEC_HI) ? 16'h0000 : 16'h0001))
        else $error("vector fetched from wrong address");
    target_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R11]
        state == SVI_VEC_LO && mem_ready |=> branch && branch_target[7:0] == $past(mem_rdata))
        else $error("branch target low byte wrong");
    mode_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R02]
        reg_hit |-> reg_rdata[GIE_BIT] == global_irq_enable && reg_rdata[7:4] == 4'h0)
        else $error("system mode read mismatch");
    // instruction pulses and acceptance override a same-cycle write
    mode_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R02]
        mode_write && !enable_interrupts_instr && !mask_all_instr && !return_from_isr && !take_irq
            |=> {4'h0, system_mode_reg} == ($past(reg_wdata) & 8'h0F))
        else $error("system mode write did not land");
    mask_clears_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R02]
        mask_all_instr && !return_from_isr |=> !global_irq_enable)
        else $error("disable instruction left global enable set");

    // ********************************
    // scenario covers
    // ********************************
    accept_c: cover property (@(posedge ref_clk) disable iff (!rst_n) irq_ack);
    full_cycle_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        irq_ack ##[1:20] branch);
    two_pending_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        $countones(pending) > 1 && irq_ack);
    return_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        branch ##[1:50] return_from_isr);
    slow_push_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        stack_push && !mem_ready);
endmodule : svi_core

// *** svi_core_model.sv ***
// svi_core_model: core-side stack and program memory responder
`timescale 1ns/1ns
module svi_core_model #(
    parameter logic [7:0] VEC_HI = 8'h3C,
    parameter logic [7:0] VEC_LO = 8'hE1
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        slow,
    input  wire logic        stack_push,
    input  wire logic [7:0]  stack_data,
    input  wire logic        vec_read,
    input  wire logic [15:0] vec_addr,
    output logic             mem_ready,
    output logic      [7:0]  mem_rdata,
    output logic      [23:0] push_log,
    output logic      [7:0]  push_cnt
);
    logic       tog;
    logic [7:0] last;
    // ****
    // memory timing
    // ****
    // slow mode stalls every other cycle to test held stack data
    always_ff @(negedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tog <= 1'h0;
        end else begin
            tog <= slow ? ~tog : 1'h1;
        end
    end
    assign mem_ready = tog;
    // unselected reads show the inverse of the last byte, never a stale copy
    always_comb begin
        if (vec_read && vec_addr == 16'h0000) begin
            mem_rdata = VEC_HI;
        end else if (vec_read && vec_addr == 16'h0001) begin
            mem_rdata = VEC_LO;
        end else begin
            mem_rdata = ~last;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            last     <= 8'h00;
            push_log <= 24'h000000;
            push_cnt <= 8'h00;
        end else begin
            if (vec_read && mem_ready) begin
                last <= mem_rdata;
            end
            if (stack_push && mem_ready) begin
                push_log <= {push_log[15:0], stack_data};
                push_cnt <= push_cnt + 8'h01;
            end
        end
    end
endmodule : svi_core_model

// *** single_vector_interrupt_logic_tb_top.sv ***
// single_vector_interrupt_logic_tb_top: self-checking bench for svi_core
`timescale 1ns/1ns
module single_vector_interrupt_logic_tb_top;
    import svi_pkg::*;
    typedef struct packed {
        logic [1:0] src;
        logic [3:0] en;
        logic       gie;
        logic       slow;
        logic       exp;
    } svi_row_s;
    localparam logic [7:0] HI = 8'h3C;
    localparam logic [7:0] LO = 8'hE1;
    localparam logic [5:0] IE = 6'h01;
    localparam logic [5:0] GIE_ON = 6'h02;
    localparam logic [5:0] GIE_OFF = 6'h04;
    localparam logic [5:0] RET = 6'h08;
    logic ref_clk, rst_n, reg_wr, slow, reg_hit, irq_request, irq_ack;
    logic stack_push, vec_read, branch, irq_busy, mem_ready;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, flags_value, mem_rdata, stack_data, push_cnt, cnt0;
    logic [15:0] pc_value, vec_addr, branch_target;
    logic [23:0] push_log;
    logic [5:0] ctl;
    logic [1:0] pins;
    logic [3:0] src_enable, pend_wr, pend_wdata, pending;
    svi_row_s rows[6];
    svi_row_s rw;
    int num_errors, num_checks, n;

    svi_core i_svi_core (.ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .reg_hit,
        .instr_end(ctl[0]), .enable_interrupts_instr(ctl[1]), .mask_all_instr(ctl[2]),
        .return_from_isr(ctl[3]), .pwm_ovf_evt(ctl[4]), .t0_match_evt(ctl[5]),
        .ext_irq_line_a(pins[0]), .ext_irq_line_b(pins[1]), .src_enable, .pend_wr, .pend_wdata,
        .pending, .pc_value, .flags_value, .mem_ready, .mem_rdata, .irq_request, .irq_ack,
        .stack_push, .stack_data, .vec_read, .vec_addr, .branch, .branch_target, .irq_busy);
    svi_core_model #(.VEC_HI(HI), .VEC_LO(LO)) i_svi_core_model (.ref_clk, .rst_n, .slow,
        .stack_push, .stack_data, .vec_read, .vec_addr, .mem_ready, .mem_rdata, .push_log, .push_cnt);

    // ****
    // helpers
    // ****
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one control pulse per call; settled outputs read 1 ns after the falling edge
    task automatic step(input logic [5:0] v);
        @(negedge ref_clk);
        ctl = v;
        #1;
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        ctl = 6'h00;
        reg_addr = a;
        reg_wr = 1'h1;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 1'h0;
        reg_addr = 8'hDF;
        #1;
    endtask : wr
    task automatic pw(input logic [3:0] w, input logic [3:0] d);
        @(negedge ref_clk);
        ctl = 6'h00;
        pend_wr = w;
        pend_wdata = d;
        @(negedge ref_clk);
        pend_wr = 4'h0;
        #1;
    endtask : pw
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    // whole run is under two hundred cycles; the 10000-cycle limit is fifty times that and cuts a hang
    initial begin
        #100000;
        num_errors++;
        print_verdict;
    end

    // ****
    // main sequence
    // ****
    initial begin
        rst_n = 1'h0;
        reg_addr = 8'hDF;
        reg_wr = 1'h0;
        reg_wdata = 8'h00;
        slow = 1'h0;
        ctl = 6'h00;
        pins = 2'h0;
        src_enable = 4'h0;
        pend_wr = 4'h0;
        pend_wdata = 4'h0;
        pc_value = 16'h1234;
        flags_value = 8'h5A;
        num_errors = 0;
        num_checks = 0;
        rows = '{'{2'h0, 4'h1, 1'h1, 1'h0, 1'h1}, '{2'h1, 4'h2, 1'h1, 1'h1, 1'h1},
                 '{2'h2, 4'h4, 1'h1, 1'h0, 1'h1}, '{2'h3, 4'h8, 1'h1, 1'h1, 1'h1},
                 '{2'h1, 4'hD, 1'h1, 1'h0, 1'h0}, '{2'h0, 4'hF, 1'h0, 1'h0, 1'h0}};
        repeat (20) @(negedge ref_clk);
        rst_n = 1'h1;
        #1;
        chk("mode_reset", 8'h00, reg_rdata);
        chk("hit", 1'h1, reg_hit);
        wr(8'h20, 8'hFF);
        chk("mode_kept", 8'h00, reg_rdata);
        reg_addr = 8'h20;
        #1;
        chk("unmapped", 9'h000, {reg_hit, reg_rdata});
        wr(8'hDF, 8'hFF);
        chk("mode_rw", 8'h0F, reg_rdata);
        wr(8'hDF, 8'h00);
        $display("test register_map done");
        for (int r = 0; r < 6; r++) begin
            rw = rows[r];
            slow = rw.slow;
            src_enable = rw.en;
            pc_value = pc_value + 16'h1111;
            cnt0 = push_cnt;
            step(rw.gie ? GIE_ON : GIE_OFF);
            if (rw.src < 2'h2) begin
                step(rw.src[0] ? 6'h20 : 6'h10);
            end else begin
                step(6'h00);
                pins[rw.src[0]] = 1'h1;
            end
            repeat (8) step(6'h00);
            chk("pending", 1'h1, pending[rw.src]);
            chk("request", rw.exp, irq_request);
            step(IE);
            chk("ack", rw.exp, irq_ack);
            step(6'h00);
            if (rw.exp) begin
                chk("gie_off", 1'h0, reg_rdata[3]);
                for (n = 0; n < 40 && branch !== 1'h1; n++) step(6'h00);
                chk("branch", 1'h1, branch);
                chk("target", {HI, LO}, branch_target);
                chk("stack", {pc_value[7:0], pc_value[15:8], flags_value}, push_log);
                chk("pushes", cnt0 + 8'h03, push_cnt);
            end
            pw(4'hF, 4'h0);
            pins = 2'h0;
            if (rw.exp) begin
                step(RET);
                step(6'h00);
                chk("gie_on", 1'h1, reg_rdata[3]);
            end
            $display("row %0d done", r);
        end
        step(6'h20);
        step(6'h00);
        pw(4'h2, 4'hF);
        chk("pend_w1", 4'h2, pending);
        pw(4'h2, 4'h0);
        chk("pend_w0", 4'h0, pending);
        $display("test pending_write done");
        wr(8'hDF, 8'h08);
        src_enable = 4'h3;
        step(6'h30);
        step(6'h00);
        chk("no_boundary", 2'h2, {irq_request, irq_ack});
        pw(4'h1, 4'h0);
        chk("poll_left", 5'h5, {pending, irq_request});
        slow = 1'h1;
        step(IE);
        chk("ack2", 1'h1, irq_ack);
        step(IE);
        chk("busy_refuse", 1'h0, irq_ack);
        step(6'h00);
        rst_n = 1'h0;
        #1;
        chk("mid_reset", 13'h0000, {pending, irq_busy, reg_rdata});
        step(6'h00);
        rst_n = 1'h1;
        step(6'h00);
        chk("after_reset", 1'h0, irq_request);
        $display("test poll_and_reset done");
        print_verdict;
    end
endmodule : single_vector_interrupt_logic_tb_top
